// *** hw/oc4h_buf_decode.sv ***
`timescale 1ns/1ps
module oc4h_buf_decode (
	input  wire logic [5:0]          pattern_i, // word bits 27..22
	output oc4h_pkg::oc4h_buf_e      type_o     // decoded buffer type
);

	always_comb begin
		// single ended wins regardless of the pin mode bits
		if (pattern_i[5:4] == oc4h_pkg::BUF_TYPE_SINGLE) begin
			type_o = oc4h_pkg::OC4H_BUF_SINGLE;
		end else if (pattern_i == oc4h_pkg::PATTERN_PECL) begin
			type_o = oc4h_pkg::OC4H_BUF_PECL;
		end else if (pattern_i == oc4h_pkg::PATTERN_LVDS) begin
			type_o = oc4h_pkg::OC4H_BUF_LVDS;
		end else if (pattern_i == oc4h_pkg::PATTERN_DISABLED) begin
			type_o = oc4h_pkg::OC4H_BUF_OFF;
		end else begin
			type_o = oc4h_pkg::OC4H_BUF_ILLEGAL;
		end
	end

endmodule // oc4h_buf_decode

// *** hw/oc4h_cfg_word.sv ***
// Notes on behaviour
// - config word lives at address 0x04
// - hold bit 4 clear keeps charge pump running
// - bits 6..12 select coarse phase
// - bits 13..19 select divider ratio
// - bit 20 enables the channel divider
// - bit 21 selects high swing, differential
// - bits 22..23 positive pin mode
// - bits 24..25 negative pin mode
// - modes: normal, inverted, high impedance, low
// - buffer bits zero means single ended
`timescale 1ns/1ps
module oc4h_cfg_word #(
	parameter logic [27:0] RESET_VALUE = oc4h_pkg::CFG_RESET_VALUE
) (
	input  wire logic        core_clk_i,     // core clock
	input  wire logic        rstn_i,         // async reset, active low
	input  wire logic [3:0]  cfg_addr_i,     // control port address
	input  wire logic [27:0] cfg_wdata_i,    // control port write data
	input  wire logic        cfg_wr_i,       // write strobe
	input  wire logic        cfg_rd_i,       // read strobe
	output logic      [27:0] cfg_rdata_o,    // read data
	output logic             cfg_ack_o,      // access answered
	input  wire logic        nvm_load_i,     // stored word valid
	input  wire logic [27:0] nvm_word_i,     // stored word
	output logic             nvm_loaded_o,   // word came from nvm
	input  wire logic        ref_lost_i,     // reference clock lost
	output logic             cp_active_o,    // charge pump running
	output logic             holdover_o,     // loop held, pump off
	output logic      [6:0]  phase_sel_o,    // coarse phase select
	output logic      [6:0]  ratio_sel_o,    // divider ratio select
	output logic             div_en_o,       // divider enable
	output logic             hi_swing_o,     // high swing select
	output logic      [2:0]  buf_type_o,     // buffer type code
	input  wire logic        clk4_i,         // channel clock sample
	output logic             pos_pin_o,      // positive pin level
	output logic             pos_pin_oe_o,   // positive pin driven
	output logic             neg_pin_o,      // negative pin level
	output logic             neg_pin_oe_o    // negative pin driven
);

	logic [27:0]         word_d;
	logic [27:0]         word_q;
	logic                loaded_d;
	logic                loaded_q;
	logic [27:0]         rdata_d;
	logic [27:0]         rdata_q;
	logic                ack_d;
	logic                ack_q;
	logic                cp_d;
	logic                cp_q;
	logic                hold_d;
	logic                hold_q;
	logic [6:0]          phase_d;
	logic [6:0]          phase_q;
	logic [6:0]          ratio_d;
	logic [6:0]          ratio_q;
	logic                div_en_d;
	logic                div_en_q;
	logic                swing_d;
	logic                swing_q;
	logic [2:0]          buf_d;
	logic [2:0]          buf_q;
	logic                hit;
	logic                se_mode;
	logic                diff_mode;
	oc4h_pkg::oc4h_buf_e buf_type;
	logic [1:0]          pin_mode [2];
	logic [1:0]          pin_val;
	logic [1:0]          pin_oe;

	assign hit = (cfg_addr_i == oc4h_pkg::CFG_WORD_ADDR);

	// register word and read port
	always_comb begin
		word_d   = word_q;
		loaded_d = loaded_q;
		rdata_d  = rdata_q;
		ack_d    = 1'b0;
		// the stored word wins over a host write in the same cycle
		if (nvm_load_i) begin
			word_d   = nvm_word_i;
			loaded_d = 1'b1;
		end else if (cfg_wr_i && hit) begin
			word_d = cfg_wdata_i;
		end
		if (cfg_wr_i || cfg_rd_i) begin
			ack_d = 1'b1;
		end
		if (cfg_rd_i) begin
			if (hit) begin
				rdata_d = word_q;
			end else begin
				rdata_d = '0;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			word_q   <= RESET_VALUE;
			loaded_q <= 1'b0;
			rdata_q  <= '0;
			ack_q    <= 1'b0;
		end else begin
			word_q   <= word_d;
			loaded_q <= loaded_d;
			rdata_q  <= rdata_d;
			ack_q    <= ack_d;
		end
	end

	oc4h_buf_decode u_buf_decode (
		.pattern_i (word_q[oc4h_pkg::BUF_PATTERN_LSB +:
			oc4h_pkg::BUF_PATTERN_W]),
		.type_o    (buf_type)
	);

	assign se_mode   = (buf_type == oc4h_pkg::OC4H_BUF_SINGLE);
	assign diff_mode = (buf_type == oc4h_pkg::OC4H_BUF_PECL) ||
		(buf_type == oc4h_pkg::OC4H_BUF_LVDS);

	assign pin_mode[0] = word_q[oc4h_pkg::POS_MODE_LSB +:
		oc4h_pkg::PIN_MODE_W];
	assign pin_mode[1] = word_q[oc4h_pkg::NEG_MODE_LSB +:
		oc4h_pkg::PIN_MODE_W];

	// one driver per pin of the channel
	for (genvar i = 0; i < 2; i++) begin : g_pin
		oc4h_pin_drive u_pin (
			.core_clk_i (core_clk_i),
			.rstn_i     (rstn_i),
			.se_mode_i  (se_mode),
			.mode_i     (pin_mode[i]),
			.clk4_i     (clk4_i),
			.pin_o      (pin_val[i]),
			.pin_oe_o   (pin_oe[i])
		);
	end

	// channel controls
	always_comb begin
		// with hold set, a lost reference freezes the pump
		hold_d   = word_q[oc4h_pkg::HOLD_BIT] && ref_lost_i;
		cp_d     = !hold_d;
		phase_d  = word_q[oc4h_pkg::PHASE_LSB +: oc4h_pkg::PHASE_W];
		ratio_d  = word_q[oc4h_pkg::RATIO_LSB +: oc4h_pkg::RATIO_W];
		div_en_d = word_q[oc4h_pkg::DIV_EN_BIT];
		swing_d  = word_q[oc4h_pkg::HI_SWING_BIT] && diff_mode;
		buf_d    = buf_type;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cp_q     <= 1'b1;
			hold_q   <= 1'b0;
			phase_q  <= '0;
			ratio_q  <= '0;
			div_en_q <= 1'b0;
			swing_q  <= 1'b0;
			buf_q    <= '0;
		end else begin
			cp_q     <= cp_d;
			hold_q   <= hold_d;
			phase_q  <= phase_d;
			ratio_q  <= ratio_d;
			div_en_q <= div_en_d;
			swing_q  <= swing_d;
			buf_q    <= buf_d;
		end
	end

	assign cfg_rdata_o  = rdata_q;
	assign cfg_ack_o    = ack_q;
	assign nvm_loaded_o = loaded_q;
	assign cp_active_o  = cp_q;
	assign holdover_o   = hold_q;
	assign phase_sel_o  = phase_q;
	assign ratio_sel_o  = ratio_q;
	assign div_en_o     = div_en_q;
	assign hi_swing_o   = swing_q;
	assign buf_type_o   = buf_q;
	assign pos_pin_o    = pin_val[0];
	assign pos_pin_oe_o = pin_oe[0];
	assign neg_pin_o    = pin_val[1];
	assign neg_pin_oe_o = pin_oe[1];

endmodule // oc4h_cfg_word

// *** hw/oc4h_pin_drive.sv ***
`timescale 1ns/1ps
module oc4h_pin_drive (
	input  wire logic       core_clk_i, // core clock
	input  wire logic       rstn_i,     // async reset, active low
	input  wire logic       se_mode_i,  // channel is single ended
	input  wire logic [1:0] mode_i,     // pin mode field {y, x}
	input  wire logic       clk4_i,     // channel clock sample
	output logic            pin_o,      // pin level
	output logic            pin_oe_o    // pin driven
);

	logic pin_d;
	logic pin_q;
	logic oe_d;
	logic oe_q;

	always_comb begin
		pin_d = 1'b0;
		oe_d  = 1'b0;
		if (se_mode_i) begin
			case (mode_i)
				oc4h_pkg::PIN_MODE_NORMAL: begin
					pin_d = clk4_i;
					oe_d  = 1'b1;
				end
				oc4h_pkg::PIN_MODE_INVERTED: begin
					pin_d = ~clk4_i;
					oe_d  = 1'b1;
				end
				oc4h_pkg::PIN_MODE_LOW: begin
					pin_d = 1'b0;
					oe_d  = 1'b1;
				end
				default: begin
					pin_d = 1'b0;
					oe_d  = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			pin_q <= pin_d;
			oe_q  <= oe_d;
		end
	end

	assign pin_o    = pin_q;
	assign pin_oe_o = oe_q;

endmodule // oc4h_pin_drive

// *** hw/oc4h_pkg.sv ***
package oc4h_pkg;

	// register map
	localparam int          ADDR_W          = 4;
	localparam logic [3:0]  CFG_WORD_ADDR   = 4'h4;
	localparam int          WORD_W          = 28;
	localparam logic [27:0] CFG_RESET_VALUE = 28'h0000000;

	// field positions
	localparam int RSVD_LO_LSB    = 0;
	localparam int RSVD_LO_W      = 4;
	localparam int HOLD_BIT       = 4;
	localparam int RSVD5_BIT      = 5;
	localparam int PHASE_LSB      = 6;
	localparam int PHASE_W        = 7;
	localparam int RATIO_LSB      = 13;
	localparam int RATIO_W        = 7;
	localparam int DIV_EN_BIT     = 20;
	localparam int HI_SWING_BIT   = 21;
	localparam int POS_MODE_LSB   = 22;
	localparam int NEG_MODE_LSB   = 24;
	localparam int PIN_MODE_W     = 2;
	localparam int BUF_TYPE_LSB   = 26;
	localparam int BUF_TYPE_W     = 2;
	localparam int BUF_PATTERN_LSB = 22;
	localparam int BUF_PATTERN_W   = 6;

	// pin mode field {y, x}
	localparam logic [1:0] PIN_MODE_NORMAL   = 2'h0;
	localparam logic [1:0] PIN_MODE_INVERTED = 2'h1;
	localparam logic [1:0] PIN_MODE_HIZ      = 2'h2;
	localparam logic [1:0] PIN_MODE_LOW      = 2'h3;

	// buffer type field {y, x}; zero means single ended
	localparam logic [1:0] BUF_TYPE_SINGLE = 2'h0;

	// bits 27..22 of the word
	localparam logic [5:0] PATTERN_PECL     = 6'h20;
	localparam logic [5:0] PATTERN_LVDS     = 6'h3A;
	localparam logic [5:0] PATTERN_DISABLED = 6'h1A;

	typedef enum logic [2:0] {
		OC4H_BUF_SINGLE,
		OC4H_BUF_PECL,
		OC4H_BUF_LVDS,
		OC4H_BUF_OFF,
		OC4H_BUF_ILLEGAL
	} oc4h_buf_e;

endpackage

// *** tb/oc4h_cfg_checker.sv ***
`timescale 1ns/1ps
module oc4h_cfg_checker (
	input  wire logic        core_clk_i,   // core clock
	input  wire logic        rstn_i,       // reset, active low
	input  wire logic [3:0]  cfg_addr_i,   // address
	input  wire logic        cfg_wr_i,     // write strobe
	input  wire logic        cfg_rd_i,     // read strobe
	input  wire logic [27:0] cfg_rdata_o,  // read data
	input  wire logic        cfg_ack_o,    // answer
	input  wire logic        nvm_load_i,   // stored word valid
	input  wire logic        nvm_loaded_o, // loaded flag
	input  wire logic        ref_lost_i,   // reference lost
	input  wire logic        cp_active_o,  // pump running
	input  wire logic        holdover_o,   // loop held
	input  wire logic        hi_swing_o,   // high swing
	input  wire logic [2:0]  buf_type_o,   // buffer type
	input  wire logic        pos_pin_oe_o, // positive pin driven
	input  wire logic        neg_pin_oe_o  // negative pin driven
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	a_ack_after_req: assert property (
		(cfg_wr_i || cfg_rd_i) |=> cfg_ack_o) else $error("ack missing");
	a_ack_no_req: assert property (
		cfg_ack_o |-> $past(cfg_wr_i || cfg_rd_i)) else $error("stray ack");
	a_other_addr_zero: assert property (
		cfg_rd_i && cfg_addr_i != 4'h4 |=> cfg_rdata_o == 28'h0000000)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (
		!cfg_rd_i |=> $stable(cfg_rdata_o)) else $error("rdata moved");
	a_pump_on: assert property (
		!ref_lost_i |=> cp_active_o) else $error("pump stopped");
	a_hold_inverse: assert property (
		holdover_o != cp_active_o) else $error("hold not inverse");
	a_hold_needs_loss: assert property (
		holdover_o |-> $past(ref_lost_i)) else $error("hold without loss");
	a_swing_diff: assert property (
		hi_swing_o |-> buf_type_o inside {3'h1, 3'h2})
		else $error("swing outside differential");
	a_pins_off_diff: assert property (
		buf_type_o != 3'h0 && $stable(buf_type_o)
		|-> !pos_pin_oe_o && !neg_pin_oe_o) else $error("pin driven");
	a_load_sticky: assert property (
		nvm_load_i || nvm_loaded_o |=> nvm_loaded_o)
		else $error("loaded flag lost");
	c_write: cover property (cfg_wr_i ##1 cfg_ack_o);
	c_hold: cover property (holdover_o);
	c_pecl: cover property (buf_type_o == 3'h1 && hi_swing_o);
endmodule // oc4h_cfg_checker
bind oc4h_cfg_word oc4h_cfg_checker oc4h_cfg_checker_inst (
	.core_clk_i(core_clk_i), .rstn_i(rstn_i), .cfg_addr_i(cfg_addr_i),
	.cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
	.cfg_ack_o(cfg_ack_o), .nvm_load_i(nvm_load_i),
	.nvm_loaded_o(nvm_loaded_o), .ref_lost_i(ref_lost_i),
	.cp_active_o(cp_active_o), .holdover_o(holdover_o),
	.hi_swing_o(hi_swing_o), .buf_type_o(buf_type_o),
	.pos_pin_oe_o(pos_pin_oe_o), .neg_pin_oe_o(neg_pin_oe_o));

// *** tb/oc4h_host_model.sv ***
`timescale 1ns/1ps
module oc4h_host_model (
	input  wire logic        core_clk_i, // core clock
	input  wire logic        ack_i,      // answer
	input  wire logic [27:0] rdata_i,    // read data
	output logic      [3:0]  addr_o,     // address
	output logic      [27:0] wdata_o,    // write data
	output logic             wr_o,       // write strobe
	output logic             rd_o        // read strobe
);
	initial begin
		addr_o = 4'h0;
		wdata_o = 28'h0000000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// one-cycle strobe; ack stands one cycle, so it is taken just after it
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [27:0] d, output logic [27:0] q, output logic ak);
		@(posedge core_clk_i);
		wr_o <= w;
		rd_o <= !w;
		addr_o <= a;
		wdata_o <= d & 28'hFFFFFF0;
		@(posedge core_clk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b0;
		#1;
		ak = ack_i;
		q = rdata_i;
	endtask
endmodule // oc4h_host_model

// *** tb/test_output4_holdover_config_register.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	failures++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_output4_holdover_config_register;
	logic        core_clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [3:0]  addr;
	logic [27:0] wdata, rdata, q;
	logic [27:0] nvm_word = 28'h0000000;
	logic        wr, rd, ack, ak, nvm_loaded, cp_active, holdover;
	logic        nvm_load = 1'b0, ref_lost = 1'b0, clk4 = 1'b1;
	logic        div_en, hi_swing, pos_pin, pos_oe, neg_pin, neg_oe;
	logic [6:0]  phase, ratio;
	logic [2:0]  buf_type;
	logic [5:0]  pats [4] = '{6'h20, 6'h3A, 6'h1A, 6'h3F};
	int          failures = 0;
	int          num_checks = 0;
	initial forever #5 core_clk_i = ~core_clk_i;
	oc4h_cfg_word oc4h_cfg_word_inst (.core_clk_i(core_clk_i),
		.rstn_i(rstn_i), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
		.cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_rdata_o(rdata), .cfg_ack_o(ack),
		.nvm_load_i(nvm_load), .nvm_word_i(nvm_word),
		.nvm_loaded_o(nvm_loaded), .ref_lost_i(ref_lost),
		.cp_active_o(cp_active), .holdover_o(holdover),
		.phase_sel_o(phase), .ratio_sel_o(ratio), .div_en_o(div_en),
		.hi_swing_o(hi_swing), .buf_type_o(buf_type), .clk4_i(clk4),
		.pos_pin_o(pos_pin), .pos_pin_oe_o(pos_oe), .neg_pin_o(neg_pin),
		.neg_pin_oe_o(neg_oe));
	oc4h_host_model oc4h_host_model_inst (.core_clk_i(core_clk_i),
		.ack_i(ack), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
		.wr_o(wr), .rd_o(rd));
	task automatic wr_word(input logic [3:0] a, input logic [27:0] d);
		oc4h_host_model_inst.xfer(1'b1, a, d, q, ak);
		`CHK("wr ack", 1'b1, ak)
	endtask
	task automatic rd_word(input logic [3:0] a, input logic [27:0] e);
		oc4h_host_model_inst.xfer(1'b0, a, 28'h0000000, q, ak);
		`CHK("rd ack", 1'b1, ak)
		`CHK("rdata", e, q)
	endtask
	// word lands on the same edge as ack, decoded outputs one edge later
	task automatic settle;
		repeat (2) @(posedge core_clk_i);
		#1;
	endtask
	task automatic report_and_stop;
		if (failures == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		settle();
		`CHK("buf single", 3'h0, buf_type)
		`CHK("pos oe", 1'b1, pos_oe)
		rd_word(4'h4, 28'h0000000);
		@(posedge core_clk_i);
		nvm_word <= 28'h5A3C150;
		nvm_load <= 1'b1;
		@(posedge core_clk_i);
		nvm_load <= 1'b0;
		settle();
		`CHK("loaded", 1'b1, nvm_loaded)
		rd_word(4'h4, 28'h5A3C150);
		wr_word(4'h4, 28'h0155540);
		settle();
		`CHK("phase", 7'h55, phase)
		`CHK("ratio", 7'h2A, ratio)
		`CHK("div on", 1'b1, div_en)
		wr_word(4'h5, 28'hFFFFFF0);
		rd_word(4'h5, 28'h0000000);
		rd_word(4'h4, 28'h0155540);
		wr_word(4'h4, 28'h0055540);
		@(posedge core_clk_i);
		ref_lost <= 1'b1;
		settle();
		`CHK("div off", 1'b0, div_en)
		`CHK("pump on", 1'b1, cp_active)
		wr_word(4'h4, 28'h0000010);
		settle();
		`CHK("pump off", 1'b0, cp_active)
		`CHK("holdover", 1'b1, holdover)
		for (int c = 0; c < 2; c++) begin
			for (int m = 0; m < 4; m++) begin
				@(posedge core_clk_i);
				clk4 <= c[0];
				wr_word(4'h4, {2'h0, 2'(m), 2'(m), 22'h0});
				settle();
				`CHK("pos oe", 1'(m != 2), pos_oe)
				`CHK("neg oe", 1'(m != 2), neg_oe)
				`CHK("pos pin", 1'(m == 0 ? c : m == 1 ? !c : 0), pos_pin)
				`CHK("neg pin", 1'(m == 0 ? c : m == 1 ? !c : 0), neg_pin)
			end
		end
		for (int i = 0; i < 4; i++) begin
			wr_word(4'h4, {pats[i], 22'h200000});
			settle();
			`CHK("buf type", 3'(i + 1), buf_type)
			`CHK("swing", 1'(i < 2), hi_swing)
			`CHK("pos off", 1'b0, pos_oe)
		end
		report_and_stop();
	end
endmodule // test_output4_holdover_config_register
